// ===== ackid_csr_pkg.sv
/*
 Package for the per-port acknowledge-ID maintenance register bank.
 Holds offsets, field positions, reset values and the shared carrier structs.
 Assumes a 32-bit word-addressed configuration register port with byte offsets.
*/
package ackid_csr_pkg;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_LINK_REQUEST = 8'h40;
    localparam logic [7:0] OFS_LINK_REPLY_STATUS = 8'h44;
    localparam logic [7:0] OFS_LOCAL_ACK_COUNTERS = 8'h48;
    localparam logic [7:0] OFS_PORT_SECOND_CONTROL = 8'h54;

    // ----------------------------------------
    // Field positions and widths
    // ----------------------------------------
    localparam int ACK_W = 6;
    localparam int STATE_W = 5;
    localparam int CMD_W = 3;
    localparam int BAUD_FLAGS_W = 10;
    localparam int BAUD_SEL_W = 4;
    localparam int BIT_REPLY_VALID = 31;
    localparam int BIT_FLUSH = 31;
    localparam int BIT_SCRAMBLE_OFF = 29;
    localparam int LSB_REPLY_ACK = 5;
    localparam int LSB_REPLY_STATE = 0;
    localparam int LSB_RX_ACK = 24;
    localparam int LSB_ACCEPT_ACK = 8;
    localparam int LSB_TX_ACK = 0;
    localparam int LSB_BAUD_FLAGS = 6;
    localparam int LSB_BAUD_SEL = 0;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [ACK_W-1:0] ACK_RESET = 6'h00;
    localparam logic [STATE_W-1:0] STATE_RESET = 5'h00;
    localparam logic [CMD_W-1:0] CMD_RESET = 3'h0;
    // Reset-device command: the partner sends no response symbol for it
    localparam logic [CMD_W-1:0] CMD_SILENT = 3'h3;
    localparam logic [ACK_W-1:0] ACK_ONE = 6'h01;

    // Link-request command carried in a transmitted symbol
    typedef struct packed {
        logic valid;
        logic [CMD_W-1:0] cmd;
    } link_req_t;

    // Captured fields of a received link-response symbol
    typedef struct packed {
        logic valid;
        logic [ACK_W-1:0] ack_state;
        logic [STATE_W-1:0] port_state;
    } link_resp_t;

    // Software register access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } cfg_req_t;

endpackage : ackid_csr_pkg

// ===== ackid_req_tracker.sv
/*
 Tracks one outstanding link-request and produces the reply-valid event.
 Assumes the transmitter pulses tx_sent once per request symbol sent, and
 that the command tells whether a link-response will follow.
*/
`timescale 1ns/1ns
module ackid_req_tracker
    import ackid_csr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic issue,
    input wire logic expects_reply,
    input wire logic tx_sent,
    input wire logic resp_seen,
    output logic reply_event
);

    logic pending_ff;
    logic expect_ff;

    // ----------------------------------------
    // Outstanding request bookkeeping
    // ----------------------------------------
    // New issue wins over completion so a back-to-back request is tracked
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pending_ff <= 1'b0;
            expect_ff <= 1'b0;
        end
        else if (issue)
        begin
            pending_ff <= 1'b1;
            expect_ff <= expects_reply;
        end
        else if (reply_event)
        begin
            pending_ff <= 1'b0;
        end
    end

    // Event: response for a reply command, or transmission for a silent one
    assign reply_event = pending_ff & (expect_ff ? resp_seen : tx_sent); // see RULE_01 see RULE_02

endmodule : ackid_req_tracker

// ===== link_maint_ackid_csr_bank.sv
/*
 Per-port link maintenance, local acknowledge-ID and second control registers.
 Assumes a single-cycle configuration register port (read data valid the
 cycle after rd), a transmitter that reports symbol sends, and a receiver
 that pulses captured link-response fields.
*/
// Operation
// RULE_01 - Reply flag sets on response, clears on read
// RULE_02 - Silent command sets flag once symbol sent
// RULE_03 - Latch response ack state into [10:5]
// RULE_04 - Latch response port state into [4:0]
// RULE_05 - Reply and ack registers need recovery option
// RULE_06 - Flush bit always reads zero
// RULE_07 - Flush discards pending, last ack = next-1
// RULE_08 - Expected rx ack writable unless flushing
// RULE_09 - Report expected packet-accepted ack id
// RULE_10 - Next tx ack write forces retransmission
// RULE_11 - Bit 29 bypasses scrambler and descrambler
// RULE_12 - Without idle two, scrambling stays enabled
// RULE_13 - Baud flags report configured line rate
// RULE_14 - Report selected baud rate in [3:0]
// RULE_15 - Request write sends link-request with command
// RULE_16 - Reserved bits read zero, ignore writes
`timescale 1ns/1ns
module link_maint_ackid_csr_bank
    import ackid_csr_pkg::*;
#(
    parameter bit SW_RECOVERY = 1'b1,
    parameter bit IDLE_SEQUENCE_TWO = 1'b1,
    parameter logic [ackid_csr_pkg::BAUD_FLAGS_W-1:0] BAUD_FLAGS = 10'h001,
    parameter logic [ackid_csr_pkg::BAUD_SEL_W-1:0] BAUD_SEL = 4'h1
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire ackid_csr_pkg::cfg_req_t cfg_req,
    output logic [31:0] cfg_rdata,
    input wire ackid_csr_pkg::link_resp_t link_resp,
    input wire logic tx_req_sent,
    input wire logic [ackid_csr_pkg::ACK_W-1:0] accept_ack_in,
    input wire logic accept_ack_load,
    input wire logic [ackid_csr_pkg::ACK_W-1:0] rx_ack_in,
    input wire logic rx_ack_load,
    input wire logic [ackid_csr_pkg::ACK_W-1:0] tx_ack_in,
    input wire logic tx_ack_load,
    output ackid_csr_pkg::link_req_t link_req,
    output logic flush_pending_acks,
    output logic retransmit,
    output logic [ackid_csr_pkg::ACK_W-1:0] last_ack_id,
    output logic [ackid_csr_pkg::ACK_W-1:0] expected_rx_ack_id,
    output logic [ackid_csr_pkg::ACK_W-1:0] expected_accept_ack_id,
    output logic [ackid_csr_pkg::ACK_W-1:0] next_tx_ack_id,
    output logic scramble_bypass
);

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    logic wr_req;
    logic wr_ack;
    logic wr_ctl2;
    logic rd_reply;
    logic flush_wr;
    logic reply_event;
    logic reply_valid_ff;
    logic [ACK_W-1:0] reply_ack_state_ff;
    logic [STATE_W-1:0] reply_port_state_ff;
    link_req_t link_req_ff;
    logic flush_ff;
    logic retransmit_ff;
    logic [ACK_W-1:0] rx_ack_ff;
    logic [ACK_W-1:0] accept_ack_ff;
    logic [ACK_W-1:0] tx_ack_ff;
    logic [ACK_W-1:0] last_ack_ff;
    logic scramble_off_ff;
    logic [31:0] cfg_rdata_ff;
    logic [31:0] nxt_rdata;

    // Recovery-only registers vanish from the map when the option is off
    assign wr_req = cfg_req.wr & SW_RECOVERY & hit(cfg_req.addr, OFS_LINK_REQUEST); // see RULE_05
    assign wr_ack = cfg_req.wr & SW_RECOVERY & hit(cfg_req.addr, OFS_LOCAL_ACK_COUNTERS); // see RULE_05
    assign wr_ctl2 = cfg_req.wr & hit(cfg_req.addr, OFS_PORT_SECOND_CONTROL);
    assign rd_reply = cfg_req.rd & SW_RECOVERY & hit(cfg_req.addr, OFS_LINK_REPLY_STATUS);
    assign flush_wr = wr_ack & cfg_req.wdata[BIT_FLUSH];

    // ----------------------------------------
    // Link-request issue
    // ----------------------------------------
    // One-cycle command pulse to the symbol generator
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            link_req_ff <= '{valid: 1'b0, cmd: CMD_RESET};
        end
        else
        begin
            link_req_ff.valid <= wr_req; // see RULE_15
            if (wr_req)
            begin
                link_req_ff.cmd <= cfg_req.wdata[CMD_W-1:0];
            end
        end
    end

    // Reset-device command draws no response from the partner
    ackid_req_tracker u_tracker (
        .clk(clk),
        .rst_b(rst_b),
        .issue(wr_req),
        .expects_reply(cfg_req.wdata[CMD_W-1:0] != CMD_SILENT),
        .tx_sent(tx_req_sent),
        .resp_seen(link_resp.valid),
        .reply_event(reply_event)
    );

    // ----------------------------------------
    // Response capture
    // ----------------------------------------
    // Set wins over the read-clear so a response in the read cycle survives
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reply_valid_ff <= 1'b0;
        end
        else if (reply_event)
        begin
            reply_valid_ff <= 1'b1; // see RULE_01 see RULE_02
        end
        else if (rd_reply)
        begin
            reply_valid_ff <= 1'b0; // see RULE_01
        end
    end

    // Fields follow every received response, newest wins
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reply_ack_state_ff <= ACK_RESET;
            reply_port_state_ff <= STATE_RESET;
        end
        else if (link_resp.valid)
        begin
            reply_ack_state_ff <= link_resp.ack_state; // see RULE_03
            reply_port_state_ff <= link_resp.port_state; // see RULE_04
        end
    end

    // ----------------------------------------
    // Acknowledge-ID counters
    // ----------------------------------------
    // Software write beats the datapath load; flush blocks the software write of the rx and tx id fields, their datapath loads still apply
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_ack_ff <= ACK_RESET;
            tx_ack_ff <= ACK_RESET;
            accept_ack_ff <= ACK_RESET;
            last_ack_ff <= ACK_RESET;
        end
        else
        begin
            if (wr_ack && !flush_wr)
            begin
                rx_ack_ff <= cfg_req.wdata[LSB_RX_ACK +: ACK_W]; // see RULE_08
                tx_ack_ff <= cfg_req.wdata[LSB_TX_ACK +: ACK_W]; // see RULE_10
            end
            else
            begin
                if (rx_ack_load)
                begin
                    rx_ack_ff <= rx_ack_in;
                end
                if (tx_ack_load)
                begin
                    tx_ack_ff <= tx_ack_in;
                end
            end
            if (flush_wr)
            begin
                last_ack_ff <= tx_ack_ff - ACK_ONE; // see RULE_07
                accept_ack_ff <= tx_ack_ff; // see RULE_07
            end
            else if (accept_ack_load)
            begin
                accept_ack_ff <= accept_ack_in; // see RULE_09
                last_ack_ff <= accept_ack_in - ACK_ONE;
            end
        end
    end

    // Command pulses to the transmitter
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            flush_ff <= 1'b0;
            retransmit_ff <= 1'b0;
        end
        else
        begin
            flush_ff <= flush_wr; // see RULE_07
            retransmit_ff <= wr_ack & ~flush_wr; // see RULE_10
        end
    end

    // ----------------------------------------
    // Second control register
    // ----------------------------------------
    // Without idle sequence two the scrambler cannot be turned off
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            scramble_off_ff <= 1'b0;
        end
        else if (wr_ctl2)
        begin
            scramble_off_ff <= cfg_req.wdata[BIT_SCRAMBLE_OFF] & IDLE_SEQUENCE_TWO; // see RULE_11 see RULE_12
        end
    end

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    always_comb
    begin
        nxt_rdata = 32'h0000_0000; // see RULE_16
        if (cfg_req.rd)
        begin
            if (SW_RECOVERY && hit(cfg_req.addr, OFS_LINK_REQUEST))
            begin
                nxt_rdata[CMD_W-1:0] = link_req_ff.cmd;
            end
            else if (SW_RECOVERY && hit(cfg_req.addr, OFS_LINK_REPLY_STATUS))
            begin
                nxt_rdata[BIT_REPLY_VALID] = reply_valid_ff;
                nxt_rdata[LSB_REPLY_ACK +: ACK_W] = reply_ack_state_ff; // see RULE_03
                nxt_rdata[LSB_REPLY_STATE +: STATE_W] = reply_port_state_ff; // see RULE_04
            end
            else if (SW_RECOVERY && hit(cfg_req.addr, OFS_LOCAL_ACK_COUNTERS))
            begin
                // Flush bit is never stored, so it reads zero
                nxt_rdata[BIT_FLUSH] = 1'b0; // see RULE_06
                nxt_rdata[LSB_RX_ACK +: ACK_W] = rx_ack_ff;
                nxt_rdata[LSB_ACCEPT_ACK +: ACK_W] = accept_ack_ff; // see RULE_09
                nxt_rdata[LSB_TX_ACK +: ACK_W] = tx_ack_ff;
            end
            else if (hit(cfg_req.addr, OFS_PORT_SECOND_CONTROL))
            begin
                nxt_rdata[BIT_SCRAMBLE_OFF] = scramble_off_ff;
                nxt_rdata[LSB_BAUD_FLAGS +: BAUD_FLAGS_W] = BAUD_FLAGS; // see RULE_13
                nxt_rdata[LSB_BAUD_SEL +: BAUD_SEL_W] = BAUD_SEL; // see RULE_14
            end
        end
    end

    // Registered read data, one cycle after rd
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cfg_rdata_ff <= 32'h0000_0000;
        end
        else
        begin
            cfg_rdata_ff <= nxt_rdata;
        end
    end

    assign cfg_rdata = cfg_rdata_ff;
    assign link_req = link_req_ff;
    assign flush_pending_acks = flush_ff;
    assign retransmit = retransmit_ff;
    assign last_ack_id = last_ack_ff;
    assign expected_rx_ack_id = rx_ack_ff;
    assign expected_accept_ack_id = accept_ack_ff;
    assign next_tx_ack_id = tx_ack_ff;
    assign scramble_bypass = scramble_off_ff; // see RULE_11

endmodule : link_maint_ackid_csr_bank

// ===== link_maint_ackid_csr_bank_sva.sv
/*
 Checker for the ackID register bank, on its top-level ports.
 Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/1ns
module link_maint_ackid_csr_bank_sva
    import ackid_csr_pkg::*;
#(
    parameter bit SW_RECOVERY = 1'b1,
    parameter bit IDLE_SEQUENCE_TWO = 1'b1,
    parameter logic [9:0] BAUD_FLAGS = 10'h001,
    parameter logic [3:0] BAUD_SEL = 4'h1
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire ackid_csr_pkg::cfg_req_t cfg_req,
    input wire logic [31:0] cfg_rdata,
    input wire ackid_csr_pkg::link_resp_t link_resp,
    input wire logic tx_req_sent,
    input wire ackid_csr_pkg::link_req_t link_req,
    input wire logic flush_pending_acks,
    input wire logic retransmit,
    input wire logic [5:0] last_ack_id,
    input wire logic [5:0] expected_rx_ack_id,
    input wire logic [5:0] expected_accept_ack_id,
    input wire logic [5:0] next_tx_ack_id,
    input wire logic scramble_bypass
);
    // ----------------------------------------
    // Decoded accesses and helpers
    // ----------------------------------------
    logic w40, w48, w54, r44, r48, r54, quiet, fl;
    logic [10:0] fields_ff;
    // Recovery registers only count when the build has them
    assign w40 = SW_RECOVERY && cfg_req.wr && cfg_req.addr == OFS_LINK_REQUEST;
    assign w48 = SW_RECOVERY && cfg_req.wr && cfg_req.addr == OFS_LOCAL_ACK_COUNTERS;
    assign w54 = cfg_req.wr && cfg_req.addr == OFS_PORT_SECOND_CONTROL;
    assign r44 = SW_RECOVERY && cfg_req.rd && cfg_req.addr == OFS_LINK_REPLY_STATUS;
    assign r48 = SW_RECOVERY && cfg_req.rd && cfg_req.addr == OFS_LOCAL_ACK_COUNTERS;
    assign r54 = cfg_req.rd && cfg_req.addr == OFS_PORT_SECOND_CONTROL;
    // No reply event of any kind in this cycle
    assign quiet = !link_resp.valid && !tx_req_sent;
    assign fl = cfg_req.wdata[31];
    // Last response fields seen on the wire
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            fields_ff <= 11'h0;
        else if (link_resp.valid)
            fields_ff <= {link_resp.ack_state, link_resp.port_state};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_req;
        w40 |=> link_req.valid && link_req.cmd == $past(cfg_req.wdata[2:0]);
    endproperty
    a_req: assert property (p_req) else $error("link request missing");
    property p_fields;
        r44 |=> cfg_rdata[10:0] == $past(fields_ff) && cfg_rdata[30:11] == 20'h0;
    endproperty
    a_fields: assert property (p_fields) else $error("reply fields wrong");
    property p_clear;
        quiet ##1 (r44 && quiet) ##1 quiet ##1 (r44 && quiet) |=> !cfg_rdata[31];
    endproperty
    a_clear: assert property (p_clear) else $error("reply flag not cleared");
    property p_zero;
        r48 |=> !cfg_rdata[31] && cfg_rdata[13:8] == $past(expected_accept_ack_id);
    endproperty
    a_zero: assert property (p_zero) else $error("ack read wrong");
    property p_flush;
        w48 && fl |=> flush_pending_acks && last_ack_id == $past(next_tx_ack_id) - ACK_ONE;
    endproperty
    a_flush: assert property (p_flush) else $error("flush wrong");
    property p_locked;
        w48 && fl |=> $stable(expected_rx_ack_id) && $stable(next_tx_ack_id);
    endproperty
    a_locked: assert property (p_locked) else $error("field written in flush");
    property p_retx;
        w48 && !fl |=> retransmit && next_tx_ack_id == $past(cfg_req.wdata[5:0])
            && expected_rx_ack_id == $past(cfg_req.wdata[29:24]);
    endproperty
    a_retx: assert property (p_retx) else $error("ack write wrong");
    property p_scr;
        w54 |=> scramble_bypass == ($past(cfg_req.wdata[29]) && IDLE_SEQUENCE_TWO);
    endproperty
    a_scr: assert property (p_scr) else $error("scramble bypass wrong");
    property p_baud;
        r54 |=> cfg_rdata[15:0] == {BAUD_FLAGS, 2'h0, BAUD_SEL} && cfg_rdata[28:16] == 13'h0;
    endproperty
    a_baud: assert property (p_baud) else $error("baud fields wrong");
endmodule : link_maint_ackid_csr_bank_sva

bind link_maint_ackid_csr_bank link_maint_ackid_csr_bank_sva #(.SW_RECOVERY(SW_RECOVERY),
    .IDLE_SEQUENCE_TWO(IDLE_SEQUENCE_TWO),
    .BAUD_FLAGS(BAUD_FLAGS), .BAUD_SEL(BAUD_SEL)) link_maint_ackid_csr_bank_sva_inst (.*);

// ===== link_maint_ackid_csr_bank_tb_top.sv
/*
 Self-checking bench for the ackID register bank and partner model.
 Assumes the checker is bound in by its own file.
*/
`timescale 1ns/1ns
module link_maint_ackid_csr_bank_tb_top;
    import ackid_csr_pkg::*;
    logic clk, rst_b, tx_req_sent, accept_ack_load, rx_ack_load, tx_ack_load;
    logic flush_pending_acks, retransmit, scramble_bypass;
    logic [31:0] cfg_rdata;
    logic [31:0] rdata_lean;
    logic bypass_lean;
    logic [5:0] accept_ack_in, rx_ack_in, tx_ack_in, last_ack_id;
    logic [5:0] expected_rx_ack_id, expected_accept_ack_id, next_tx_ack_id;
    cfg_req_t cfg_req;
    link_resp_t link_resp;
    link_req_t link_req;
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;
    // ----------------------------------------
    // Clock, hang guard and instances
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_mismatch++;
            close_out();
        end
    end
    link_maint_ackid_csr_bank #(.BAUD_FLAGS(10'h2a5), .BAUD_SEL(4'h6)) link_maint_ackid_csr_bank_inst (.clk,
        .rst_b, .cfg_req, .cfg_rdata, .link_resp, .tx_req_sent, .accept_ack_in, .accept_ack_load, .rx_ack_in,
        .rx_ack_load, .tx_ack_in, .tx_ack_load, .link_req, .flush_pending_acks, .retransmit, .last_ack_id,
        .expected_rx_ack_id, .expected_accept_ack_id, .next_tx_ack_id, .scramble_bypass);
    link_partner_model link_partner_model_inst (.clk, .rst_b, .link_req, .link_resp, .tx_req_sent);
    // Lean build on the same bus: no recovery registers, no idle sequence two
    if (1'b1)
    begin : g_lean
        link_maint_ackid_csr_bank #(.SW_RECOVERY(1'b0), .IDLE_SEQUENCE_TWO(1'b0)) link_maint_ackid_csr_bank_inst (
            .clk, .rst_b, .cfg_req, .cfg_rdata(rdata_lean), .link_resp, .tx_req_sent, .accept_ack_in,
            .accept_ack_load, .rx_ack_in, .rx_ack_load, .tx_ack_in, .tx_ack_load, .link_req(),
            .flush_pending_acks(), .retransmit(), .last_ack_id(), .expected_rx_ack_id(),
            .expected_accept_ack_id(), .next_tx_ack_id(), .scramble_bypass(bypass_lean));
    end
    // Compare and bus cycles, inputs moved 1 ns after the edge
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        #1 cfg_req = '{1'b1, 1'b0, a, d};
        @(posedge clk);
        #1 cfg_req.wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        @(posedge clk);
        #1 cfg_req = '{1'b0, 1'b1, a, 32'h0};
        @(posedge clk);
        #1 cfg_req.rd = 1'b0;
        q = cfg_rdata;
    endtask : rd
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        rd(a, q);
        chk(q, e);
    endtask : rdc
    // Reset values, refused writes, unmapped place
    task automatic t_reset();
        wr(OFS_LINK_REPLY_STATUS, 32'hffff_ffff);
        rdc(OFS_LINK_REPLY_STATUS, 32'h0);
        rdc(OFS_LOCAL_ACK_COUNTERS, 32'h0);
        rdc(8'h4c, 32'h0);
        rdc(OFS_PORT_SECOND_CONTROL, 32'h0000_a946);
    endtask : t_reset
    // Every command; reset-device (3) has no reply and keeps old fields
    task automatic t_reply();
        logic [31:0] q;
        logic [10:0] f;
        f = 11'h0;
        for (int c = 0; c < 8; c++)
        begin
            wr(OFS_LINK_REQUEST, 32'hffff_fff8 | c);
            chk(link_req, {1'b1, c[2:0]});
            if (c != 3)
                f = {3'h5, c[2:0], 2'h2, c[2:0]};
            q = 32'h0;
            for (int i = 0; i < 20 && q[31] !== 1'b1; i++)
                rd(OFS_LINK_REPLY_STATUS, q);
            chk(q, {1'b1, 20'h0, f});
            rdc(OFS_LINK_REPLY_STATUS, {21'h0, f});
        end
    endtask : t_reply
    // Lean build hides recovery registers that the full build fills
    task automatic t_lean();
        logic [31:0] q;
        rd(OFS_LINK_REQUEST, q);
        chk(q, 32'h7);
        chk(rdata_lean, 32'h0);
        rd(OFS_LINK_REPLY_STATUS, q);
        chk(q, 32'h5f7);
        chk(rdata_lean, 32'h0);
        rd(OFS_LOCAL_ACK_COUNTERS, q);
        chk(rdata_lean, 32'h0);
    endtask : t_lean
    // Datapath loads, software write, then flush with locked fields
    task automatic t_ack();
        @(posedge clk);
        #1 {tx_ack_load, tx_ack_in, accept_ack_load, accept_ack_in} = {1'b1, 6'h10, 1'b1, 6'h07};
        {rx_ack_load, rx_ack_in} = {1'b1, 6'h33};
        @(posedge clk);
        #1 {tx_ack_load, accept_ack_load, rx_ack_load} = 3'h0;
        rdc(OFS_LOCAL_ACK_COUNTERS, 32'h3300_0710);
        wr(OFS_LOCAL_ACK_COUNTERS, 32'h7fff_ffea);
        chk(retransmit, 1'b1);
        rdc(OFS_LOCAL_ACK_COUNTERS, 32'h3f00_072a);
        wr(OFS_LOCAL_ACK_COUNTERS, 32'hffff_ffff);
        chk({flush_pending_acks, last_ack_id}, {1'b1, 6'h29});
        chk({expected_rx_ack_id, expected_accept_ack_id, next_tx_ack_id}, {6'h3f, 6'h2a, 6'h2a});
        rdc(OFS_LOCAL_ACK_COUNTERS, 32'h3f00_2a2a);
    endtask : t_ack
    // Scrambling bypass on and off
    task automatic t_scr();
        logic [31:0] q;
        wr(OFS_PORT_SECOND_CONTROL, 32'hffff_ffff);
        chk(scramble_bypass, 1'b1);
        chk(bypass_lean, 1'b0);
        rd(OFS_PORT_SECOND_CONTROL, q);
        chk(q, 32'h2000_a946);
        chk(rdata_lean, 32'h0000_0041);
        wr(OFS_PORT_SECOND_CONTROL, 32'h0);
        chk(scramble_bypass, 1'b0);
    endtask : t_scr
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out
    // Main sequence
    initial
    begin
        rst_b = 1'b0;
        cfg_req = '0;
        {accept_ack_in, rx_ack_in, tx_ack_in} = 18'h0;
        {accept_ack_load, rx_ack_load, tx_ack_load} = 3'h0;
        repeat (20) @(posedge clk);
        #1 rst_b = 1'b1;
        t_reset();
        t_reply();
        t_lean();
        t_ack();
        t_scr();
        close_out();
    end
endmodule : link_maint_ackid_csr_bank_tb_top

// ===== link_partner_model.sv
/*
 Behavioural far-end port: sends the request symbol, then replies unless the command is reset-device.
 Assumes the bank's registered one-cycle link_req.valid pulse.
*/
`timescale 1ns/1ns
module link_partner_model
    import ackid_csr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire ackid_csr_pkg::link_req_t link_req,
    output ackid_csr_pkg::link_resp_t link_resp,
    output logic tx_req_sent
);
    logic [2:0] cmd;
    // Delay grows with the command, so both prompt and slow replies occur
    initial
    begin
        link_resp = '0;
        tx_req_sent = 1'b0;
        forever
        begin
            @(posedge clk);
            #2;
            if (rst_b && link_req.valid)
            begin
                cmd = link_req.cmd;
                repeat (cmd) @(posedge clk);
                #1 tx_req_sent = 1'b1;
                @(posedge clk);
                #1 tx_req_sent = 1'b0;
                // Reset-device command gets no response symbol
                if (cmd != 3'h3)
                begin
                    repeat (2) @(posedge clk);
                    #1 link_resp = {1'b1, 3'h5, cmd, 2'h2, cmd};
                    @(posedge clk);
                    // Fields flip when idle so stale values never pass
                    #1 link_resp = {1'b0, ~link_resp[10:0]};
                end
            end
        end
    end
endmodule : link_partner_model
